// [core/flash_host.sv]
// Host controller for a boot-sector flash: reads, writes, identification.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - High-voltage A9 read gives maker/part codes.
// - Permanent protection only via programming equipment.
// - Identify and write operations start only after unlock cycles.
// - Write needs CE, WE low, OE high.
// - Identification persists until reset command.
module flash_host
	import flash_host_pkg::*;
#(
	parameter bit TOP_BOOT = 1'b1
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// User request
	input  wire logic        req_valid,
	input  var  req_t        req,
	output logic             req_ready,
	// User answer
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic [2:0]       rsp_sector,
	output logic             ident_mode,
	// Flash pins
	output pins_t            pins,
	output logic             reset_hv,
	input  wire logic [7:0]  dq_in,
	output logic [7:0]       dq_out,
	output logic             dq_oe
);

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_U1   = 3'b001,
		H_U2   = 3'b010,
		H_CMD  = 3'b011,
		H_ONE  = 3'b100,
		H_DONE = 3'b101
	} host_t;

	host_t       st_q, st_d;
	req_t        rq_q, rq_d;
	logic        id_q, id_d;
	logic        busy_q, busy_d;
	logic        rv_q, rv_d;
	logic [7:0]  rsp_q, rsp_d;
	logic [2:0]  sec_q, sec_d;
	logic        cyc_start;
	logic        cyc_wr;
	logic [17:0] cyc_addr;
	logic [7:0]  cyc_data;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;
	pins_t       cyc_pins;

	// ----------------------------------------------------------------
	// Bus cycle engine
	// ----------------------------------------------------------------
	flash_cycle u_cyc (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.start    (cyc_start),
		.is_write (cyc_wr),
		.addr     (cyc_addr),
		.wdata    (cyc_data),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.pins     (cyc_pins),
		.dq_in    (dq_in),
		.dq_out   (dq_out),
		.dq_oe    (dq_oe)
	);

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	// The host assumes the device starts in read-array after power-up,
	// so idle means plain reads need no preceding command.
	always_comb
	begin
		st_d      = st_q;
		rq_d      = rq_q;
		id_d      = id_q;
		busy_d    = busy_q;
		rv_d      = 1'b0;
		rsp_d     = rsp_q;
		sec_d     = sec_q;
		cyc_start = 1'b0;
		cyc_wr    = 1'b1;
		cyc_addr  = rq_q.addr;
		cyc_data  = rq_q.data;
		case (st_q)
			H_IDLE:
			begin
				if (req_valid)
				begin
					rq_d  = req;
					sec_d = sector_of(TOP_BOOT, req.addr[17:13]);
					case (req.op)
						OP_IDENT, OP_WRITE:
							st_d = H_U1;
						default:
							st_d = H_ONE;
					endcase
				end
			end
			H_U1:
			begin
				cyc_addr = UNLOCK1_ADDR;
				cyc_data = UNLOCK1_DATA;
				cyc_start = !busy_q;
				busy_d = 1'b1;
				if (cyc_done)
				begin
					busy_d = 1'b0;
					st_d   = H_U2;
				end
			end
			H_U2:
			begin
				cyc_addr = UNLOCK2_ADDR;
				cyc_data = UNLOCK2_DATA;
				cyc_start = !busy_q;
				busy_d = 1'b1;
				if (cyc_done)
				begin
					busy_d = 1'b0;
					st_d   = (rq_q.op == OP_IDENT) ? H_CMD : H_ONE;
				end
			end
			H_CMD:
			begin
				cyc_addr = UNLOCK1_ADDR;
				cyc_data = IDENT_CMD;
				cyc_start = !busy_q;
				busy_d = 1'b1;
				if (cyc_done)
				begin
					busy_d = 1'b0;
					id_d   = 1'b1;
					st_d   = H_DONE;
				end
			end
			H_ONE:
			begin
				// Reads with OE low; writes or exit as one write cycle.
				cyc_wr = rq_q.op == OP_WRITE || rq_q.op == OP_EXITID;
				if (rq_q.op == OP_EXITID)
					cyc_data = RESET_CMD;
				cyc_start = !busy_q;
				busy_d = 1'b1;
				if (cyc_done)
				begin
					busy_d = 1'b0;
					rsp_d  = cyc_wr ? 8'h00 : cyc_rdata;
					if (rq_q.op == OP_EXITID)
						id_d = 1'b0;
					st_d = H_DONE;
				end
			end
			default:
			begin
				rv_d = 1'b1;
				st_d = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q   <= H_IDLE;
			rq_q   <= '0;
			id_q   <= 1'b0;
			busy_q <= 1'b0;
			rv_q   <= 1'b0;
			rsp_q  <= 8'h00;
			sec_q  <= 3'h0;
		end
		else
		begin
			st_q   <= st_d;
			rq_q   <= rq_d;
			id_q   <= id_d;
			busy_q <= busy_d;
			rv_q   <= rv_d;
			rsp_q  <= rsp_d;
			sec_q  <= sec_d;
		end
	end

	// High voltage on A9 is only raised for an explicit programmer read.
	always_comb
	begin
		pins       = cyc_pins;
		pins.a9_hv = rq_q.op == OP_HVID && st_q == H_ONE;
	end
	// Temporary unprotect is never requested by this host.
	assign reset_hv   = 1'b0;
	assign req_ready  = (st_q == H_IDLE);
	assign rsp_valid  = rv_q;
	assign rsp_data   = rsp_q;
	assign rsp_sector = sec_q;
	assign ident_mode = id_q;

	a_ident_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		(id_q && !(st_q == H_ONE && rq_q.op == OP_EXITID)) |=> id_q)
		else $error("identification mode left without reset command");
	a_write_unlocked: assert property (@(posedge mclk) disable iff (!arst_n)
		(st_q == H_IDLE && req_valid && req.op == OP_WRITE) |=> st_q == H_U1)
		else $error("write issued without unlock cycles");
	a_hv_only_read: assert property (@(posedge mclk) disable iff (!arst_n)
		pins.a9_hv |-> pins.we_n)
		else $error("high voltage during a write strobe");
	// A request offered alongside the answer is taken at once, so ready
	// may drop on the next cycle only in that case.
	a_resp_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		rsp_valid |=> !rsp_valid && (req_ready || $past(req_valid)))
		else $error("answer pulse longer than one cycle");
	a_dq_float: assert property (@(posedge mclk) disable iff (!arst_n)
		!pins.oe_n |-> !dq_oe)
		else $error("host drives data while device output enabled");
	c_ident: cover property (@(posedge mclk) disable iff (!arst_n)
		$rose(id_q));
	c_exit: cover property (@(posedge mclk) disable iff (!arst_n)
		$fell(id_q));
	c_write: cover property (@(posedge mclk) disable iff (!arst_n)
		rv_q && rq_q.op == OP_WRITE);

endmodule
`default_nettype wire

// [core/flash_host_pkg.sv]
// Package: constants and types for the boot-sector flash host controller.
package flash_host_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// Command bus cycles (standard unlock sequence)
	// ----------------------------------------------------------------
	localparam logic [17:0] UNLOCK1_ADDR = 18'h00555;
	localparam logic [17:0] UNLOCK2_ADDR = 18'h002aa;
	localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
	localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
	localparam logic [7:0]  IDENT_CMD    = 8'h90;
	localparam logic [7:0]  RESET_CMD    = 8'hf0;

	// ----------------------------------------------------------------
	// Identification read addresses (low byte)
	// ----------------------------------------------------------------
	localparam logic [7:0] ID_MAKER_LOW = 8'h00;
	localparam logic [7:0] ID_PART_LOW  = 8'h01;
	localparam logic [7:0] ID_PROT_LOW  = 8'h02;

	// ----------------------------------------------------------------
	// Bus cycle timing at 25 MHz (40 ns period)
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int STROBE_NS     = 80;
	localparam int SETUP_NS      = 40;
	// Strobes far wider than the 5 ns glitch filter of the device.
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
	localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);

	// ----------------------------------------------------------------
	// Operations requested by the user side
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ   = 3'b000,
		OP_WRITE  = 3'b001,
		OP_IDENT  = 3'b010,
		OP_EXITID = 3'b011,
		OP_HVID   = 3'b100
	} op_t;

	typedef struct packed {
		op_t         op;
		logic [17:0] addr;
		logic [7:0]  data;
	} req_t;

	// Pin bundle towards the flash.
	typedef struct packed {
		logic        cs_n;
		logic        oe_n;
		logic        we_n;
		logic        a9_hv;
		logic [17:0] addr;
	} pins_t;

	// Sector index from address bits 17..13 for either boot variant.
	function automatic logic [2:0] sector_of(input logic top_boot,
		input logic [4:0] a);
		logic [2:0] s;
		s = 3'h0;
		if (top_boot)
		begin
			if (a[4:3] != 2'b11)
				s = {1'b0, a[4:3]};
			else if (!a[2])
				s = 3'h3;
			else if (a[1])
				s = 3'h6;
			else
				s = a[0] ? 3'h5 : 3'h4;
		end
		else
		begin
			if (a[4:3] != 2'b00)
				s = 3'(3 + a[4:3]);
			else if (a[2])
				s = 3'h3;
			else if (!a[1])
				s = 3'h0;
			else
				s = a[0] ? 3'h2 : 3'h1;
		end
		return s;
	endfunction

endpackage

// [core/flash_cycle.sv]
// Single flash bus cycle engine: drives strobes and data pins.
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
	import flash_host_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Cycle request
	input  wire logic        start,
	input  wire logic        is_write,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  wdata,
	output logic             done,
	output logic [7:0]       rdata,
	// Flash pins
	output pins_t            pins,
	input  wire logic [7:0]  dq_in,
	output logic [7:0]       dq_out,
	output logic             dq_oe
);

	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_SETUP = 2'b01,
		C_PULSE = 2'b10,
		C_HOLD  = 2'b11
	} cyc_t;

	cyc_t        st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        wr_q, wr_d;
	logic [17:0] addr_q, addr_d;
	logic [7:0]  wd_q, wd_d;
	logic [7:0]  rd_q, rd_d;
	logic [7:0]  s1_q, s2_q, s3_q;

	// ----------------------------------------------------------------
	// Read data synchroniser
	// ----------------------------------------------------------------
	// Three stages; data is taken only once the last two agree.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
			s3_q <= 8'h00;
		end
		else
		begin
			s1_q <= dq_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		wr_d   = wr_q;
		addr_d = addr_q;
		wd_d   = wd_q;
		rd_d   = rd_q;
		case (st_q)
			C_IDLE:
			begin
				if (start)
				begin
					st_d   = C_SETUP;
					cnt_d  = SETUP_CNT;
					wr_d   = is_write;
					addr_d = addr;
					wd_d   = wdata;
				end
			end
			C_SETUP:
			begin
				if (cnt_q <= 4'h1)
				begin
					st_d  = C_PULSE;
					cnt_d = STROBE_CNT + 4'h2;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			C_PULSE:
			begin
				// Reads wait two extra cycles for synchroniser latency.
				if (cnt_q <= 4'h1 || (wr_q && cnt_q <= 4'h3))
				begin
					if (!wr_q && s2_q == s3_q)
						rd_d = s3_q;
					st_d = C_HOLD;
				end
				else
					cnt_d = cnt_q - 4'h1;
			end
			default:
				st_d = C_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q   <= C_IDLE;
			cnt_q  <= 4'h0;
			wr_q   <= 1'b0;
			addr_q <= 18'h0;
			wd_q   <= 8'h00;
			rd_q   <= 8'h00;
		end
		else
		begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			wr_q   <= wr_d;
			addr_q <= addr_d;
			wd_q   <= wd_d;
			rd_q   <= rd_d;
		end
	end

	// A write is CE low and WE low with OE high; a read never lowers WE.
	always_comb
	begin
		pins.cs_n  = (st_q == C_IDLE);
		pins.we_n  = !(wr_q && st_q == C_PULSE);
		pins.oe_n  = wr_q || st_q == C_IDLE;
		pins.a9_hv = 1'b0;
		pins.addr  = addr_q;
	end
	assign dq_out = wd_q;
	assign dq_oe  = wr_q && st_q != C_IDLE;
	assign done   = (st_q == C_HOLD);
	assign rdata  = rd_q;

	a_write_combo: assert property (@(posedge mclk) disable iff (!arst_n)
		!pins.we_n |-> (!pins.cs_n && pins.oe_n))
		else $error("write strobe without legal pin combination");
	a_never_both: assert property (@(posedge mclk) disable iff (!arst_n)
		!(!pins.we_n && !pins.oe_n))
		else $error("write and output enable low together");
	a_strobe_width: assert property (@(posedge mclk) disable iff (!arst_n)
		$fell(pins.we_n) |-> !pins.we_n [*2])
		else $error("write strobe too short");

endmodule
`default_nettype wire

// [dv/flash_dev_model.sv]
// Behavioural model of the boot-sector flash as the host sees it.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter bit         TOP_BOOT = 1'b1,
	parameter logic [7:0] MAKER    = 8'h5a, // Arbitrary code.
	parameter logic [7:0] PART     = 8'h3c, // Arbitrary code.
	parameter logic [6:0] PROT     = 7'h00
)
(
	// Host side
	input  wire pins_t      pins,
	input  wire logic       reset_hv,
	input  wire logic [7:0] dq_out,
	input  wire logic       dq_oe,
	output logic [7:0]      dq_in
);
	// ----------------------------------------------------------------
	// Command state and write log
	// ----------------------------------------------------------------
	logic [1:0]  step  = 2'd0;
	logic        ident = 1'b0;
	logic [7:0]  last  = 8'h00;
	logic [17:0] wa [3];
	logic [7:0]  wd [3];
	int          wr_cnt = 0;
	realtime     t_fall = 0;
	logic        supply_lockout = 1'b0; // Raised by the bench.
	logic        pu_write = 1'b0;
	int          we_rises = 0;

	function automatic logic [2:0] sec(input logic [17:0] a);
		if (TOP_BOOT)
			return a < 18'h30000 ? 3'(a[17:16]) : a < 18'h38000 ? 3'd3 :
				a < 18'h3a000 ? 3'd4 : a < 18'h3c000 ? 3'd5 : 3'd6;
		return a < 18'h04000 ? 3'd0 : a < 18'h06000 ? 3'd1 :
			a < 18'h08000 ? 3'd2 : a < 18'h10000 ? 3'd3 : 3'(a[17:16]) + 3'd3;
	endfunction

	function automatic logic [7:0] rd(input logic [17:0] a);
		logic p;
		p = PROT[sec(a)] && !reset_hv;
		if (pins.a9_hv || ident)
			return a[1] ? {7'h00, p} : a[0] ? PART : MAKER;
		return a[7:0] ^ {a[17:13], 3'h5};
	endfunction

	task automatic accept(input logic [17:0] a, input logic [7:0] d);
		wa[2] = wa[1];
		wd[2] = wd[1];
		wa[1] = wa[0];
		wd[1] = wd[0];
		wa[0] = a;
		wd[0] = d;
		wr_cnt++;
		if (d == RESET_CMD)
		begin
			ident = 1'b0;
			step = 2'd0;
		end
		else if (step == 0 && a == UNLOCK1_ADDR && d == UNLOCK1_DATA)
			step = 2'd1;
		else if (step == 1 && a == UNLOCK2_ADDR && d == UNLOCK2_DATA)
			step = 2'd2;
		else
		begin
			if (step == 2 && a == UNLOCK1_ADDR && d == IDENT_CMD)
				ident = 1'b1;
			step = 2'd0;
		end
	endtask

	always @(negedge pins.we_n)
		t_fall = $realtime;

	// A write combination held while power comes up is never taken.
	initial
		#1 pu_write = pins.we_n === 1'b0 && pins.cs_n === 1'b0 &&
			pins.oe_n === 1'b1;

	// Short strobes are ignored, as a noise filter would; low supply
	// resets the command state and drops every write until it recovers.
	always @(posedge pins.we_n)
	begin
		we_rises++;
		if (supply_lockout)
		begin
			ident = 1'b0;
			step = 2'd0;
		end
		else if (!(pu_write && we_rises == 1) && !pins.cs_n &&
			pins.oe_n && $realtime - t_fall >= 5)
			accept(pins.addr, dq_oe ? dq_out : 8'hxx);
	end

	// A released bus shows the inverse of the last byte, never a hold.
	always @*
		if (!pins.cs_n && !pins.oe_n)
		begin
			last = rd(pins.addr);
			dq_in = last;
		end
		else
			dq_in = ~last;
endmodule
`default_nettype wire

// [dv/flash_host_tb.sv]
// Self-checking testbench for the flash host controller.
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb
	import flash_host_pkg::*;
;
	localparam logic [7:0] MAKER  = 8'h5a; // Arbitrary code.
	localparam logic [7:0] PART_T = 8'h3c; // Arbitrary code.
	localparam logic [7:0] PART_B = 8'hc3; // Arbitrary code.
	localparam logic [6:0] PROT   = 7'h08;

	logic       mclk = 1'b0;
	logic       arst_n = 1'b0;
	logic       req_valid = 1'b0;
	req_t       req = '0;
	logic       ready, rv, rv_b, idm, idm_b, oe, oe_b, hv, hv_b;
	logic [7:0] rdat, rdat_b, dqi, dqi_b, dqo, dqo_b;
	logic [2:0] rsec, rsec_b;
	pins_t      pins, pins_b;
	int         mismatches = 0;
	int         tests_run = 0;

	flash_host #(.TOP_BOOT(1'b1)) u_dut (.mclk(mclk), .arst_n(arst_n),
		.req_valid(req_valid), .req(req), .req_ready(ready),
		.rsp_valid(rv), .rsp_data(rdat), .rsp_sector(rsec),
		.ident_mode(idm), .pins(pins), .reset_hv(hv), .dq_in(dqi),
		.dq_out(dqo), .dq_oe(oe));
	flash_host #(.TOP_BOOT(1'b0)) u_dut_b (.mclk(mclk), .arst_n(arst_n),
		.req_valid(req_valid), .req(req), .req_ready(),
		.rsp_valid(rv_b), .rsp_data(rdat_b), .rsp_sector(rsec_b),
		.ident_mode(idm_b), .pins(pins_b), .reset_hv(hv_b), .dq_in(dqi_b),
		.dq_out(dqo_b), .dq_oe(oe_b));
	flash_dev_model #(.TOP_BOOT(1'b1), .MAKER(MAKER), .PART(PART_T),
		.PROT(PROT)) u_dev (.pins(pins), .reset_hv(hv), .dq_out(dqo),
		.dq_oe(oe), .dq_in(dqi));
	flash_dev_model #(.TOP_BOOT(1'b0), .MAKER(MAKER), .PART(PART_B),
		.PROT(PROT)) u_dev_b (.pins(pins_b), .reset_hv(hv_b),
		.dq_out(dqo_b), .dq_oe(oe_b), .dq_in(dqi_b));

	initial
		forever #20 mclk = ~mclk;

	task automatic chk(input string n, input logic [25:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic tally_and_finish;
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic [7:0] mem(input logic [17:0] a);
		return a[7:0] ^ {a[17:13], 3'h5};
	endfunction

	task automatic op(input op_t o, input logic [17:0] a, logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		req_valid <= 1'b1;
		req <= '{o, a, d};
		@(posedge mclk);
		while (ready !== 1'b1 && n < 50)
		begin
			@(posedge mclk);
			n++;
		end
		req_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		while (rv !== 1'b1 && n < 200);
		chk("rsp_valid", {rv, rv_b}, 2'b11);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("idle", {pins.cs_n, pins.oe_n, pins.we_n, pins.a9_hv, oe, ready,
			idm}, 7'b1110010);
		chk("no_unprotect", {hv, hv_b}, 2'b00);
	endtask

	task automatic t_map;
		logic [27:0] tab [17] = '{28'h0000000, 28'h03fff00, 28'h0400001,
			28'h0600002, 28'h07fff02, 28'h0800003, 28'h0ffff03, 28'h1000014,
			28'h2ffff25, 28'h3000036, 28'h37fff36, 28'h3800046, 28'h39fff46,
			28'h3a00056, 28'h3bfff56, 28'h3c00066, 28'h3ffff66};
		foreach (tab[i])
		begin
			op(OP_READ, tab[i][25:8], 8'h00);
			chk("sector_top", rsec, tab[i][7:4]);
			chk("sector_bot", rsec_b, tab[i][3:0]);
			chk("array", {rdat, rdat_b}, {2{mem(tab[i][25:8])}});
		end
	endtask

	task automatic t_write;
		int c;
		c = u_dev.wr_cnt;
		op(OP_WRITE, 18'h12345, RESET_CMD);
		chk("write_rsp", {rdat, rdat_b}, 16'h0000);
		chk("write_count", 26'(u_dev.wr_cnt - c), 3);
		chk("unlock1", {u_dev.wa[2], u_dev.wd[2]},
			{UNLOCK1_ADDR, UNLOCK1_DATA});
		chk("unlock2", {u_dev.wa[1], u_dev.wd[1]},
			{UNLOCK2_ADDR, UNLOCK2_DATA});
		chk("command", {u_dev.wa[0], u_dev.wd[0]}, {18'h12345, RESET_CMD});
	endtask

	task automatic read_ids(input op_t o);
		op(o, 18'h3a100, 8'h00);
		chk("maker", {rdat, rdat_b}, {MAKER, MAKER});
		op(o, 18'h00001, 8'h00);
		chk("part", {rdat, rdat_b}, {PART_T, PART_B});
		op(o, 18'h30002, 8'h00);
		chk("prot_a", {rdat, rdat_b}, 16'h0100);
		op(o, 18'h08002, 8'h00);
		chk("prot_b", {rdat, rdat_b}, 16'h0001);
	endtask

	task automatic t_ident;
		op(OP_IDENT, 18'h00000, 8'h00);
		chk("ident_on", {idm, idm_b}, 2'b11);
		read_ids(OP_READ);
		read_ids(OP_READ);
		op(OP_EXITID, 18'h00000, 8'h00);
		chk("ident_off", {idm, idm_b}, 2'b00);
		op(OP_READ, 18'h08002, 8'h00);
		chk("array_back", rdat, mem(18'h08002));
	endtask

	task automatic t_lockout;
		int c;
		c = u_dev.wr_cnt;
		u_dev.supply_lockout = 1'b1;
		u_dev_b.supply_lockout = 1'b1;
		op(OP_IDENT, 18'h00000, 8'h00);
		chk("lockout_writes", 26'(u_dev.wr_cnt - c), 0);
		op(OP_READ, 18'h00001, 8'h00);
		chk("lockout_read", {rdat, rdat_b}, {2{mem(18'h00001)}});
		u_dev.supply_lockout = 1'b0;
		u_dev_b.supply_lockout = 1'b0;
		op(OP_EXITID, 18'h00000, 8'h00);
		chk("lockout_exit", {idm, idm_b}, 2'b00);
	endtask

	task automatic t_hvid;
		read_ids(OP_HVID);
		chk("hv_no_ident", idm, 1'b0);
	endtask

	always @(posedge mclk)
	begin
		if (!pins.we_n)
			chk("write_strobe", {pins.cs_n, pins.oe_n}, 2'b01);
		if (oe)
			chk("bus_turn", pins.oe_n, 1'b1);
		if (idm)
			chk("a9_level", pins.a9_hv, 1'b0);
	end

	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish;
	end

	initial
	begin
		@(posedge mclk);
		#1;
		t_reset;
		@(posedge mclk);
		arst_n <= 1'b1;
		t_map;
		t_write;
		t_ident;
		t_lockout;
		t_hvid;
		tally_and_finish;
	end
endmodule
`default_nettype wire
